// ---- include/lcb_map.vh ----
`ifndef LCB_MAP_VH
`define LCB_MAP_VH
// ==========================================
// Register offsets
`define LCB_CH1_CTRL      8'h10
`define LCB_CH1_ILIM      8'h11
`define LCB_CH2_CTRL      8'h15
`define LCB_CH2_ILIM      8'h16
`define LCB_ADC_CFG       8'h1A
`define LCB_REF_BASE      8'h20
`define LCB_IRQ_STAT      8'h24
`define LCB_IRQ_MASK      8'h25
`define LCB_LIVE_STAT     8'h26
// ==========================================
// Per-channel control register fields
`define LCB_MODE_BIT      0
`define LCB_PLR_OFF_BIT   2
`define LCB_DISC_BIT      3
`define LCB_SRC_LSB       5
`define LCB_SRC_MSB       7
`define LCB_CTRL_WMASK    8'hED
`define LCB_CTRL_RESET    8'h08
`define LCB_ILIM_RESET    8'hFF
// ==========================================
// Shared ADC register fields, channel 2 sits 4 bits higher
`define LCB_RANGE_BIT     0
`define LCB_CMES_BIT      1
`define LCB_SENSE_BIT     2
`define LCB_CH_STRIDE     4
`define LCB_ADC_RESET     8'h00
// ==========================================
// Reference registers: low byte, then {shape, code[9:8]}
`define LCB_SHAPE_BIT     7
`define LCB_REF_RESET     10'h000
// ==========================================
// Source code that routes the sense or current node
`define LCB_SRC_LOOP      3'h4
// ==========================================
// Threshold step per code in microamps
`define LCB_STEP_LOW_UA   20'h0_0177
`define LCB_STEP_HIGH_UA  20'h0_0BB8
// ==========================================
// Converter route codes
`define LCB_RT_OFF        3'h0
`define LCB_RT_PLR        3'h1
`define LCB_RT_PAD        3'h2
`define LCB_RT_CUR        3'h3
`define LCB_RT_SUPPLY     3'h4
`define LCB_RT_VBL        3'h5
`define LCB_RT_LDA        3'h6
`endif

// ---- src/lcb_config_bank.v ----
// Contract
// - Sense bit picks monitor node or pad
// - Quantity bit picks power or current
// - Mode bit picks power or current loop
// - 10-bit reference and 8-bit threshold codes
// - Resistor-off bit disconnects internal resistor
// - Shape bit picks log or linear reference
// - Threshold equals code times step and factor
// - Zero code disables trip in current mode
// - Zero code keeps trip in power mode
// - Linear reference disables overcurrent trip
// - Overcurrent with protection disables channel
// - Range bit sets 0.375 or 3 mA step
// - Readable saturation flag per channel
// - Tripped channel waits for enable cycle
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "lcb_map.vh"

module lcb_config_bank #(
  parameter NCH = 2
) (
  // Clock and reset.
  input  wire                core_clk,
  input  wire                reset,
  // Register port.
  input  wire [7:0]          reg_addr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata,
  // Channel pins and analog status.
  input  wire [NCH-1:0]      channel_enable_pin,
  input  wire [NCH-1:0]      overcurrent_cmp,
  input  wire [NCH-1:0]      driver_saturation_flag,
  // Per-channel configuration towards the analog loop.
  output reg  [NCH-1:0]      regulation_mode,
  output reg  [NCH-1:0]      internal_resistor_off,
  output reg  [NCH*10-1:0]   loop_reference_code,
  output reg  [NCH-1:0]      reference_shape_bit,
  output reg  [NCH*8-1:0]    overcurrent_threshold_code,
  output reg  [NCH-1:0]      current_range_select,
  output reg  [NCH*20-1:0]   overcurrent_step_ua,
  output reg  [NCH*20-1:0]   overcurrent_base_ua,
  output reg  [NCH-1:0]      overcurrent_protect_en,
  output reg  [NCH*3-1:0]    adc_source_select,
  output reg  [NCH-1:0]      adc_sense_point_sel,
  output reg  [NCH-1:0]      measure_quantity_sel,
  output reg  [NCH*3-1:0]    adc_route,
  // Channel drive and interrupt.
  output reg  [NCH-1:0]      channel_on,
  output reg                 irq
);

  // ==========================================
  // Shared registers
  reg  [7:0]       adc_cfg_r;
  reg  [7:0]       irq_mask_r;
  reg  [2*NCH-1:0] irq_stat_r;
  reg  [2*NCH-1:0] irq_stat_nxt;
  reg  [7:0]       rdata_nxt;
  wire [NCH-1:0]   trip_evt;
  wire [NCH-1:0]   sat_evt;
  wire [NCH-1:0]   tripped;
  wire [NCH*8-1:0] ctrl_all;
  wire [NCH*8-1:0] ilim_all;
  wire [NCH*11-1:0] ref_all;

  // Shared ADC register holds both channels' range, quantity and sense bits.
  always @(posedge core_clk) begin
    if (reset) begin
      adc_cfg_r <= `LCB_ADC_RESET;
    end else if (reg_wr && reg_addr == `LCB_ADC_CFG) begin
      adc_cfg_r <= reg_wdata;
    end
  end

  // ==========================================
  // Per-channel logic
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      localparam [7:0] CTRL_A = (i == 0) ? `LCB_CH1_CTRL : `LCB_CH2_CTRL;
      localparam [7:0] ILIM_A = (i == 0) ? `LCB_CH1_ILIM : `LCB_CH2_ILIM;
      localparam [7:0] REFL_A = `LCB_REF_BASE + 2 * i;
      localparam [7:0] REFH_A = `LCB_REF_BASE + 2 * i + 1;
      localparam       SH     = `LCB_CH_STRIDE * i;

      reg  [7:0] ctrl_r;
      reg  [7:0] ilim_r;
      reg  [9:0] ref_r;
      reg        shape_r;
      reg        trip_r;
      reg        sat_q_r;
      reg        en_q_r;
      wire       mode_cur;
      wire       linear;
      wire       protect;
      wire [2:0] src;
      wire       rng_low;
      wire       cmes;
      wire       sense;
      reg  [2:0] route_nxt;

      assign mode_cur = ctrl_r[`LCB_MODE_BIT];
      assign linear   = shape_r;
      assign src      = ctrl_r[`LCB_SRC_MSB:`LCB_SRC_LSB];
      assign rng_low  = adc_cfg_r[`LCB_RANGE_BIT + SH];
      assign cmes     = adc_cfg_r[`LCB_CMES_BIT + SH];
      assign sense    = adc_cfg_r[`LCB_SENSE_BIT + SH];

      // Each channel decodes only its own addresses, so writes never cross.
      always @(posedge core_clk) begin
        if (reset) begin
          ctrl_r  <= `LCB_CTRL_RESET;
          ilim_r  <= `LCB_ILIM_RESET;
          ref_r   <= `LCB_REF_RESET;
          shape_r <= 1'b0;
        end else if (reg_wr) begin
          if (reg_addr == CTRL_A) begin
            ctrl_r <= reg_wdata & `LCB_CTRL_WMASK;
          end
          if (reg_addr == ILIM_A) begin
            ilim_r <= reg_wdata;
          end
          if (reg_addr == REFL_A) begin
            ref_r[7:0] <= reg_wdata;
          end
          if (reg_addr == REFH_A) begin
            ref_r[9:8] <= reg_wdata[1:0];
            shape_r    <= reg_wdata[`LCB_SHAPE_BIT];
          end
        end
      end

      // Protection is off for a linear reference, or a zero code in current mode.
      assign protect = !linear && !(mode_cur && ilim_r == 8'h00);

      // A trip latches until the enable pin is taken low.
      always @(posedge core_clk) begin
        if (reset) begin
          trip_r  <= 1'b0;
          sat_q_r <= 1'b0;
          en_q_r  <= 1'b0;
        end else begin
          sat_q_r <= driver_saturation_flag[i];
          en_q_r  <= channel_enable_pin[i];
          if (!channel_enable_pin[i]) begin
            trip_r <= 1'b0;
          end else if (overcurrent_cmp[i] && protect) begin
            trip_r <= 1'b1;
          end
        end
      end

      assign trip_evt[i] = !trip_r && channel_enable_pin[i] && overcurrent_cmp[i] && protect;
      assign sat_evt[i]  = driver_saturation_flag[i] && !sat_q_r;
      assign tripped[i]  = trip_r;
      assign ctrl_all[i*8 +: 8] = ctrl_r;
      assign ilim_all[i*8 +: 8] = ilim_r;
      assign ref_all[i*11 +: 11] = {shape_r, ref_r};

      // Converter input routing from source code, quantity and sense bits.
      always @* begin
        route_nxt = `LCB_RT_OFF;
        case (src)
          `LCB_SRC_LOOP: begin
            if (cmes) begin
              route_nxt = `LCB_RT_CUR;
            end else if (sense) begin
              route_nxt = `LCB_RT_PAD;
            end else begin
              route_nxt = `LCB_RT_PLR;
            end
          end
          3'h5:    route_nxt = `LCB_RT_SUPPLY;
          3'h6:    route_nxt = `LCB_RT_VBL;
          3'h7:    route_nxt = `LCB_RT_LDA;
          default: route_nxt = `LCB_RT_OFF;
        endcase
      end

      // Registered outputs towards the analog loop.
      always @(posedge core_clk) begin
        if (reset) begin
          regulation_mode[i]            <= 1'b0;
          internal_resistor_off[i]      <= 1'b0;
          loop_reference_code[i*10 +: 10] <= `LCB_REF_RESET;
          reference_shape_bit[i]        <= 1'b0;
          overcurrent_threshold_code[i*8 +: 8] <= `LCB_ILIM_RESET;
          current_range_select[i]       <= 1'b0;
          overcurrent_step_ua[i*20 +: 20] <= `LCB_STEP_HIGH_UA;
          overcurrent_base_ua[i*20 +: 20] <= 20'h0_0000;
          overcurrent_protect_en[i]     <= 1'b0;
          adc_source_select[i*3 +: 3]   <= 3'h0;
          adc_sense_point_sel[i]        <= 1'b0;
          measure_quantity_sel[i]       <= 1'b0;
          adc_route[i*3 +: 3]           <= `LCB_RT_OFF;
          channel_on[i]                 <= 1'b0;
        end else begin
          regulation_mode[i]            <= mode_cur;
          internal_resistor_off[i]      <= ctrl_r[`LCB_PLR_OFF_BIT];
          loop_reference_code[i*10 +: 10] <= ref_r;
          reference_shape_bit[i]        <= shape_r;
          overcurrent_threshold_code[i*8 +: 8] <= ilim_r;
          current_range_select[i]       <= rng_low;
          overcurrent_step_ua[i*20 +: 20] <= rng_low ? `LCB_STEP_LOW_UA
                                                     : `LCB_STEP_HIGH_UA;
          overcurrent_base_ua[i*20 +: 20] <= ilim_r * (rng_low ? `LCB_STEP_LOW_UA
                                                               : `LCB_STEP_HIGH_UA);
          overcurrent_protect_en[i]     <= protect;
          adc_source_select[i*3 +: 3]   <= src;
          adc_sense_point_sel[i]        <= sense;
          measure_quantity_sel[i]       <= cmes;
          adc_route[i*3 +: 3]           <= route_nxt;
          channel_on[i] <= channel_enable_pin[i] && !ctrl_r[`LCB_DISC_BIT]
                           && !trip_r && !trip_evt[i];
        end
      end
    end
  endgenerate

  // ==========================================
  // Interrupt status: hardware set wins over a write-one clear.
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (reg_wr && reg_addr == `LCB_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~reg_wdata[2*NCH-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | {sat_evt, trip_evt};
  end

  // Status, mask and interrupt line.
  always @(posedge core_clk) begin
    if (reset) begin
      irq_stat_r <= {2*NCH{1'b0}};
      irq_mask_r <= 8'h00;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (reg_wr && reg_addr == `LCB_IRQ_MASK) begin
        irq_mask_r <= reg_wdata;
      end
      irq <= |(irq_stat_nxt & irq_mask_r[2*NCH-1:0]);
    end
  end

  // ==========================================
  // Read decode; unmapped addresses read zero.
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `LCB_CH1_CTRL:  rdata_nxt = ctrl_all[7:0];
      `LCB_CH1_ILIM:  rdata_nxt = ilim_all[7:0];
      `LCB_CH2_CTRL:  rdata_nxt = ctrl_all[15:8];
      `LCB_CH2_ILIM:  rdata_nxt = ilim_all[15:8];
      `LCB_ADC_CFG:   rdata_nxt = adc_cfg_r;
      8'h20:          rdata_nxt = ref_all[7:0];
      8'h21:          rdata_nxt = {ref_all[10], 5'h00, ref_all[9:8]};
      8'h22:          rdata_nxt = ref_all[18:11];
      8'h23:          rdata_nxt = {ref_all[21], 5'h00, ref_all[20:19]};
      `LCB_IRQ_STAT:  rdata_nxt = {4'h0, irq_stat_r};
      `LCB_IRQ_MASK:  rdata_nxt = irq_mask_r;
      `LCB_LIVE_STAT: rdata_nxt = {2'h0, channel_on, tripped, driver_saturation_flag};
      default:        rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands for the one cycle after the strobe.
  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // lcb_config_bank
`default_nettype wire

// ---- bench/lcb_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Checker of the configuration bank outputs.
module lcb_checker #(
  parameter NCH = 2
) (
  // Clock, reset and register writes.
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  // Channel pins and configuration outputs.
  input wire logic [NCH-1:0]    channel_enable_pin,
  input wire logic [NCH-1:0]    overcurrent_cmp,
  input wire logic [NCH-1:0]    regulation_mode,
  input wire logic [NCH-1:0]    internal_resistor_off,
  input wire logic [NCH-1:0]    reference_shape_bit,
  input wire logic [NCH*8-1:0]  overcurrent_threshold_code,
  input wire logic [NCH-1:0]    current_range_select,
  input wire logic [NCH*20-1:0] overcurrent_step_ua,
  input wire logic [NCH*20-1:0] overcurrent_base_ua,
  input wire logic [NCH-1:0]    overcurrent_protect_en,
  input wire logic [NCH-1:0]    adc_sense_point_sel,
  input wire logic [NCH-1:0]    measure_quantity_sel,
  input wire logic [NCH-1:0]    channel_on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Write decodes for the three configuration offsets.
  wire w10 = reg_wr && reg_addr == 8'h10;
  wire w15 = reg_wr && reg_addr == 8'h15;
  wire w1a = reg_wr && reg_addr == 8'h1A;
  // An armed trip on channel 1.
  sequence s_trip0;
    channel_on[0] && channel_enable_pin[0] && overcurrent_cmp[0] && overcurrent_protect_en[0];
  endsequence
  a_mode_write: assert property (w10 |-> ##2 regulation_mode[0] == $past(reg_wdata[0], 2))
    else $error("mode differs from write");
  a_resistor_off: assert property (w15 |-> ##2 internal_resistor_off[1] == $past(reg_wdata[2], 2))
    else $error("resistor bit differs from write");
  a_sense_sel: assert property (w1a |-> ##2 adc_sense_point_sel[1] == $past(reg_wdata[6], 2))
    else $error("sense bit differs from write");
  a_quantity_sel: assert property (w1a |-> ##2 measure_quantity_sel[0] == $past(reg_wdata[1], 2))
    else $error("quantity bit differs from write");
  a_channel_indep: assert property (w15 |-> ##2 regulation_mode[0] == $past(regulation_mode[0]))
    else $error("channel 1 mode moved on channel 2 write");
  a_protect_arm: assert property (!$past(reset) |-> overcurrent_protect_en[0] == (!reference_shape_bit[0]
    && !(regulation_mode[0] && overcurrent_threshold_code[7:0] == 8'h00)))
    else $error("protection arm wrong");
  a_step_range: assert property (!$past(reset) |-> overcurrent_step_ua[19:0] ==
    (current_range_select[0] ? 20'h0_0177 : 20'h0_0BB8))
    else $error("step wrong");
  a_base_code: assert property (!$past(reset) |-> overcurrent_base_ua[39:20] ==
    overcurrent_threshold_code[15:8] * overcurrent_step_ua[39:20])
    else $error("threshold base wrong");
  a_trip_off: assert property (s_trip0 |=> !channel_on[0])
    else $error("channel not shut off");
  a_trip_hold: assert property (s_trip0 ##1 channel_enable_pin[0] [*3] |-> !channel_on[0])
    else $error("tripped channel came back");
endmodule // lcb_checker

bind lcb_config_bank lcb_checker #(.NCH(NCH)) u_chk (
  .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .channel_enable_pin(channel_enable_pin), .overcurrent_cmp(overcurrent_cmp),
  .regulation_mode(regulation_mode), .internal_resistor_off(internal_resistor_off),
  .reference_shape_bit(reference_shape_bit),
  .overcurrent_threshold_code(overcurrent_threshold_code),
  .current_range_select(current_range_select), .overcurrent_step_ua(overcurrent_step_ua),
  .overcurrent_base_ua(overcurrent_base_ua), .overcurrent_protect_en(overcurrent_protect_en),
  .adc_sense_point_sel(adc_sense_point_sel), .measure_quantity_sel(measure_quantity_sel),
  .channel_on(channel_on));
`default_nettype wire

// ---- bench/lcb_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Host controller that programs the registers.
module lcb_host (
  // Clock.
  input wire logic        core_clk,
  // Register port.
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input wire logic [7:0]  reg_rdata
);
  // Bus idles with no strobe from time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write cycle, then one idle cycle so strobes never collide.
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  // One read cycle; data is taken in the following cycle only.
  task rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
endmodule // lcb_host
`default_nettype wire

// ---- bench/laser_loop_config_bank_test.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Self-checking bench of the configuration bank.
module laser_loop_config_bank_test;
  logic        core_clk, reset, reg_wr, reg_rd, irq;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv, c1, c2, ad, t1, t2, s1, s2, r1, r2;
  logic [1:0]  pin, cmp, sat, mode, poff, shape, rsel, prot, sns, qty, con;
  logic [15:0] thr;
  logic [19:0] refc;
  logic [39:0] step, base;
  logic [5:0]  src, route;
  int          err_count, compares, i;
  // Clock generator.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  lcb_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  lcb_config_bank dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .channel_enable_pin(pin), .overcurrent_cmp(cmp), .driver_saturation_flag(sat),
    .regulation_mode(mode), .internal_resistor_off(poff), .loop_reference_code(refc),
    .reference_shape_bit(shape), .overcurrent_threshold_code(thr),
    .current_range_select(rsel), .overcurrent_step_ua(step), .overcurrent_base_ua(base),
    .overcurrent_protect_en(prot), .adc_source_select(src), .adc_sense_point_sel(sns),
    .measure_quantity_sel(qty), .adc_route(route), .channel_on(con), .irq(irq));
  // Compares one value and counts it.
  task chk(input string n, input logic [19:0] e, input logic [19:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Expected step, arming and converter route.
  function logic [19:0] stp(input logic r);
    return r ? 20'h0_0177 : 20'h0_0BB8;
  endfunction
  function logic prt(input logic m, input logic s, input logic [7:0] c);
    return !s && !(m && c == 8'h00);
  endfunction
  function logic [2:0] rte(input logic [2:0] s, input logic q, input logic f);
    if (!s[2]) return 3'h0;
    if (s[1:0] == 2'b00) return q ? 3'h3 : (f ? 3'h2 : 3'h1);
    return {1'b0, s[1:0]} + 3'h3;
  endfunction
  // Checks one channel's outputs against what was written.
  task cfg_chk(input int k, input logic [7:0] c, input logic [7:0] a, input logic [7:0] t,
               input logic s);
    logic [3:0] n;
    n = a[4*k+:4];
    chk("mode", c[0], mode[k]);
    chk("resistor", c[2], poff[k]);
    chk("shape", s, shape[k]);
    chk("threshold", t, thr[8*k+:8]);
    chk("step", stp(n[0]), step[20*k+:20]);
    chk("base", t * stp(n[0]), base[20*k+:20]);
    chk("armed", prt(c[0], s, t), prot[k]);
    chk("route", rte(c[7:5], n[1], n[2]), route[3*k+:3]);
    chk("source", c[7:5], src[3*k+:3]);
    chk("range", n[0], rsel[k]);
    chk("sense", n[2], sns[k]);
    chk("quantity", n[1], qty[k]);
  endtask
  // Prints the counts and the verdict, then stops.
  task results;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    results();
  end
  // Main sequence.
  initial begin
    reset = 1'b1;
    pin = 2'b00;
    cmp = 2'b00;
    sat = 2'b00;
    void'($urandom(24607));
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    host.rd(8'h10, rv);
    chk("ctrl reset", 8'h08, rv);
    host.rd(8'h11, rv);
    chk("code reset", 8'hFF, rv);
    host.rd(8'h1A, rv);
    chk("adc reset", 8'h00, rv);
    host.rd(8'h3F, rv);
    chk("unmapped", 8'h00, rv);
    $display("test reset done");
    pin <= 2'b11;
    for (i = 0; i < 12; i++) begin
      c1 = $urandom;
      c2 = $urandom;
      ad = $urandom;
      t1 = (i < 3) ? 8'h00 : $urandom;
      t2 = (i < 6) ? 8'h00 : $urandom;
      s1 = $urandom;
      s2 = $urandom;
      r1 = $urandom;
      r2 = $urandom;
      if (i == 1) c1[7:5] = 3'h4;
      if (i == 2) c2[7:5] = 3'h4;
      host.wr(8'h10, c1);
      host.wr(8'h15, c2);
      host.wr(8'h1A, ad);
      host.wr(8'h11, t1);
      host.wr(8'h16, t2);
      host.wr(8'h21, s1);
      host.wr(8'h23, s2);
      host.wr(8'h20, r1);
      host.wr(8'h22, r2);
      repeat (2) @(posedge core_clk);
      cfg_chk(0, c1, ad, t1, s1[7]);
      cfg_chk(1, c2, ad, t2, s2[7]);
      chk("reference 1", {s1[1:0], r1}, refc[9:0]);
      chk("reference 2", {s2[1:0], r2}, refc[19:10]);
      host.rd(8'h10, rv);
      chk("ctrl read", c1 & 8'hED, rv);
    end
    $display("test random config done");
    host.wr(8'h10, 8'h00);
    host.wr(8'h11, 8'h00);
    host.wr(8'h21, 8'h00);
    host.wr(8'h25, 8'h0F);
    repeat (3) @(posedge core_clk);
    chk("on", 1'b1, con[0]);
    cmp <= 2'b01;
    @(posedge core_clk);
    cmp <= 2'b00;
    repeat (2) @(posedge core_clk);
    chk("tripped", 1'b0, con[0]);
    chk("irq", 1'b1, irq);
    repeat (3) @(posedge core_clk);
    chk("held off", 1'b0, con[0]);
    host.wr(8'h24, 8'h01);
    repeat (2) @(posedge core_clk);
    chk("irq clear", 1'b0, irq);
    pin <= 2'b10;
    @(posedge core_clk);
    pin <= 2'b11;
    repeat (3) @(posedge core_clk);
    chk("re-enabled", 1'b1, con[0]);
    host.wr(8'h21, 8'h80);
    repeat (2) @(posedge core_clk);
    cmp <= 2'b01;
    repeat (3) @(posedge core_clk);
    cmp <= 2'b00;
    chk("linear on", 1'b1, con[0]);
    sat <= 2'b10;
    repeat (3) @(posedge core_clk);
    host.rd(8'h26, rv);
    chk("sat live", 2'b10, rv[1:0]);
    host.rd(8'h24, rv);
    chk("sat status", 1'b1, rv[3]);
    chk("sat irq", 1'b1, irq);
    $display("test trip and status done");
    results();
  end
endmodule // laser_loop_config_bank_test
`default_nettype wire
